// >>> verilog/amh_core.sv
// execution core: operand resolution, alu results, flags and halt control
`timescale 1ns/1ps
`default_nettype none
module amh_core (
   input wire logic clk,
   input wire logic reset_n,
   input wire amh_pkg::amh_instr_t instr,
   output logic instr_ready,
   input wire logic ext_irq,
   input wire amh_pkg::amh_wr_t host_wr,
   output logic clk_run,
   output logic frozen,
   output logic [15:0] pc,
   output logic [3:0] flags,
   output logic [7:0] rd_data,
   input wire logic [7:0] rd_addr,
   output logic [7:0] halt_guard_register
);
   // =====================================================
   // state
   // =====================================================
   typedef struct packed {
      amh_pkg::amh_state_t st;
      amh_pkg::amh_op_t op;
      logic [2:0] mode;
      logic [7:0] dst_a;
      logic [7:0] src_f;
      logic [7:0] dst_v;
      logic [7:0] src_v;
      logic [3:0] flags;
      logic [15:0] pc;
      logic [7:0] guard;
      logic [2:0] irq_sync;
      logic irq_level;
   } amh_core_state_t;

   amh_core_state_t s_r;
   amh_core_state_t s_nxt;
   logic [7:0] regs_r [0:255];
   logic [7:0] alu_res;
   logic alu_store;
   logic [3:0] alu_flags;
   logic rf_we;
   logic [7:0] rf_addr;
   logic [7:0] rf_data;

   function automatic amh_pkg::amh_op_t decode_op(input logic [7:0] opc);
      if (opc == amh_pkg::OP_ASR_R || opc == amh_pkg::OP_ASR_IR)
         return amh_pkg::AMH_OP_ASR;
      else if (opc == amh_pkg::OP_HALT)
         return amh_pkg::AMH_OP_HALT;
      else if (opc >= amh_pkg::OP_SUB_BASE && opc <= amh_pkg::OP_SUB_BASE + 8'h04)
         return amh_pkg::AMH_OP_SUB;
      else if (opc >= amh_pkg::OP_ITM_BASE && opc <= amh_pkg::OP_ITM_BASE + 8'h04)
         return amh_pkg::AMH_OP_ITM;
      else if (opc >= amh_pkg::OP_ZTM_BASE && opc <= amh_pkg::OP_ZTM_BASE + 8'h04)
         return amh_pkg::AMH_OP_ZTM;
      else if (opc >= amh_pkg::OP_XOR_BASE && opc <= amh_pkg::OP_XOR_BASE + 8'h04)
         return amh_pkg::AMH_OP_XOR;
      return amh_pkg::AMH_OP_NONE;
   endfunction

   // working register number maps into the file above the working base
   function automatic logic [7:0] wreg(input logic [3:0] n);
      return {amh_pkg::WREG_BASE, n};
   endfunction

   function automatic logic [2:0] decode_mode(input logic [7:0] opc);
      if (opc == amh_pkg::OP_ASR_R)
         return amh_pkg::MODE_GG;
      else if (opc == amh_pkg::OP_ASR_IR)
         return amh_pkg::MODE_GIR;
      return 3'(opc[3:0] - 4'h2);
   endfunction

   amh_alu i_amh_alu (
      .op(s_r.op),
      .dst(s_r.dst_v),
      .src(s_r.src_v),
      .flags_in(s_r.flags),
      .result(alu_res),
      .store(alu_store),
      .flags_out(alu_flags)
   );

   // =====================================================
   // next state
   // =====================================================
   always_comb begin
      logic [7:0] da;
      logic [7:0] sv;
      da = 8'h00;
      sv = 8'h00;
      s_nxt = s_r;
      s_nxt.irq_sync = {s_r.irq_sync[1:0], ext_irq};
      if (s_r.irq_sync[2] == s_r.irq_sync[1])
         s_nxt.irq_level = s_r.irq_sync[2];
      if (host_wr.we && host_wr.addr == 8'hff && s_r.st != amh_pkg::AMH_ST_FROZEN)
         s_nxt.guard = host_wr.data;
      case (s_r.st)
         amh_pkg::AMH_ST_IDLE: begin
            if (instr.valid) begin
               s_nxt.op = decode_op(instr.opcode);
               s_nxt.mode = decode_mode(instr.opcode);
               s_nxt.dst_a = instr.dst_addr;
               s_nxt.src_f = instr.src_field;
               s_nxt.st = amh_pkg::AMH_ST_FETCH;
            end
         end
         amh_pkg::AMH_ST_FETCH: begin
            // operand addressing resolved here, one cycle ahead of the alu
            case (s_r.mode)
               amh_pkg::MODE_RR: begin
                  da = wreg(s_r.dst_a[3:0]);
                  sv = regs_r[wreg(s_r.src_f[3:0])];
               end
               amh_pkg::MODE_RIR: begin
                  da = wreg(s_r.dst_a[3:0]);
                  sv = regs_r[regs_r[wreg(s_r.src_f[3:0])]];
               end
               amh_pkg::MODE_GG: begin
                  da = s_r.dst_a;
                  sv = regs_r[s_r.src_f];
               end
               amh_pkg::MODE_GIR: begin
                  da = s_r.op == amh_pkg::AMH_OP_ASR ? regs_r[s_r.dst_a] : s_r.dst_a;
                  sv = regs_r[regs_r[s_r.src_f]];
               end
               amh_pkg::MODE_GIM: begin
                  da = s_r.dst_a;
                  sv = s_r.src_f;
               end
               default: begin
                  da = s_r.dst_a;
                  sv = 8'h00;
               end
            endcase
            s_nxt.dst_a = da;
            s_nxt.dst_v = regs_r[da];
            s_nxt.src_v = sv;
            s_nxt.st = amh_pkg::AMH_ST_EXEC;
         end
         amh_pkg::AMH_ST_EXEC: begin
            s_nxt.st = amh_pkg::AMH_ST_IDLE;
            s_nxt.pc = s_r.pc + 16'h0001;
            if (s_r.op == amh_pkg::AMH_OP_HALT) begin
               if (s_r.guard == amh_pkg::HALT_KEY)
                  s_nxt.st = amh_pkg::AMH_ST_FROZEN;
               else
                  s_nxt.pc = amh_pkg::RESET_VECTOR;
            end else begin
               s_nxt.flags = alu_flags;
            end
         end
         amh_pkg::AMH_ST_FROZEN: begin
            s_nxt = s_r;
            s_nxt.irq_sync = {s_r.irq_sync[1:0], ext_irq};
            if (s_r.irq_sync[2] == s_r.irq_sync[1])
               s_nxt.irq_level = s_r.irq_sync[2];
            if (s_r.irq_level)
               s_nxt.st = amh_pkg::AMH_ST_IDLE;
         end
         default: begin
            s_nxt.st = amh_pkg::AMH_ST_IDLE;
         end
      endcase
   end

   // =====================================================
   // registers
   // =====================================================
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '{st: amh_pkg::AMH_ST_IDLE, op: amh_pkg::AMH_OP_NONE, mode: 3'h0, dst_a: 8'h00,
                  src_f: 8'h00, dst_v: 8'h00, src_v: 8'h00, flags: amh_pkg::FLAGS_RESET,
                  pc: amh_pkg::RESET_VECTOR, guard: amh_pkg::GUARD_RESET, irq_sync: 3'h0,
                  irq_level: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // register file write port: the alu result wins over the host port
   always_comb begin
      rf_we = 1'b0;
      rf_addr = host_wr.addr;
      rf_data = host_wr.data;
      if (s_r.st == amh_pkg::AMH_ST_EXEC && alu_store) begin
         rf_we = 1'b1;
         rf_addr = s_r.dst_a;
         rf_data = alu_res;
      end else if (host_wr.we && s_r.st != amh_pkg::AMH_ST_FROZEN) begin
         rf_we = 1'b1;
      end
   end

   // register file keeps contents across reset and freeze
   always_ff @(posedge clk) begin
      if (rf_we)
         regs_r[rf_addr] <= rf_data;
   end

   assign instr_ready = (s_r.st == amh_pkg::AMH_ST_IDLE);
   assign frozen = (s_r.st == amh_pkg::AMH_ST_FROZEN);
   assign clk_run = ~frozen;
   assign pc = s_r.pc;
   assign flags = s_r.flags;
   assign halt_guard_register = s_r.guard;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rd_data <= 8'h00;
      else
         rd_data <= regs_r[rd_addr];
   end

   // =====================================================
   // checks
   // =====================================================
   sequence halt_keyed;
      s_r.st == amh_pkg::AMH_ST_EXEC && s_r.op == amh_pkg::AMH_OP_HALT && s_r.guard == amh_pkg::HALT_KEY;
   endsequence
   sequence halt_unkeyed;
      s_r.st == amh_pkg::AMH_ST_EXEC && s_r.op == amh_pkg::AMH_OP_HALT && s_r.guard != amh_pkg::HALT_KEY;
   endsequence
   sequence exec_halt;
      s_r.st == amh_pkg::AMH_ST_EXEC && s_r.op == amh_pkg::AMH_OP_HALT;
   endsequence
   sequence exec_asr;
      s_r.st == amh_pkg::AMH_ST_EXEC && s_r.op == amh_pkg::AMH_OP_ASR;
   endsequence
   sequence exec_sub;
      s_r.st == amh_pkg::AMH_ST_EXEC && s_r.op == amh_pkg::AMH_OP_SUB;
   endsequence
   sequence exec_mask;
      s_r.st == amh_pkg::AMH_ST_EXEC && (s_r.op == amh_pkg::AMH_OP_ITM || s_r.op == amh_pkg::AMH_OP_ZTM);
   endsequence
   sequence exec_xor;
      s_r.st == amh_pkg::AMH_ST_EXEC && s_r.op == amh_pkg::AMH_OP_XOR;
   endsequence
   sequence irq_wake;
      frozen && s_r.irq_level;
   endsequence

   chk_halt_freezes: assert property (@(posedge clk) disable iff (!reset_n)
      halt_keyed |=> frozen && !clk_run)
      else $error("keyed halt did not freeze");
   chk_halt_no_key: assert property (@(posedge clk) disable iff (!reset_n)
      halt_unkeyed |=> !frozen && pc == amh_pkg::RESET_VECTOR)
      else $error("unkeyed halt did not reload pc");
   chk_halt_flags: assert property (@(posedge clk) disable iff (!reset_n)
      exec_halt |=> $stable(flags))
      else $error("halt changed flags");
   chk_frozen_hold: assert property (@(posedge clk) disable iff (!reset_n)
      frozen && $past(frozen) |-> $stable(flags) && $stable(pc) && $stable(halt_guard_register))
      else $error("state changed while frozen");
   chk_frozen_regs: assert property (@(posedge clk) disable iff (!reset_n)
      frozen |-> !rf_we)
      else $error("register file written while frozen");
   chk_wake_cause: assert property (@(posedge clk) disable iff (!reset_n)
      $fell(frozen) |-> $past(s_r.irq_level))
      else $error("frozen state left without interrupt");
   chk_irq_wake: assert property (@(posedge clk) disable iff (!reset_n)
      irq_wake |=> !frozen && $stable(pc))
      else $error("interrupt did not end the frozen state");
   chk_asr_result: assert property (@(posedge clk) disable iff (!reset_n)
      exec_asr |=> flags[amh_pkg::FLAG_C] == $past(s_r.dst_v[0]) && !flags[amh_pkg::FLAG_V])
      else $error("shift flags wrong");
   chk_asr_bits: assert property (@(posedge clk) disable iff (!reset_n)
      exec_asr |-> rf_we && rf_addr == s_r.dst_a && rf_data[7] == s_r.dst_v[7] && rf_data[6] == s_r.dst_v[7]
      && rf_data[5:0] == s_r.dst_v[6:1])
      else $error("shift result bits wrong");
   chk_asr_zero_sign: assert property (@(posedge clk) disable iff (!reset_n)
      exec_asr |=> flags[amh_pkg::FLAG_Z] == ($past(s_r.dst_v[7:1]) == 7'h00)
      && flags[amh_pkg::FLAG_S] == $past(s_r.dst_v[7]))
      else $error("shift zero or sign flag wrong");
   chk_sub_result: assert property (@(posedge clk) disable iff (!reset_n)
      exec_sub |-> rf_we && rf_addr == s_r.dst_a && 8'(rf_data + s_r.src_v) == s_r.dst_v)
      else $error("subtract result wrong");
   chk_sub_borrow: assert property (@(posedge clk) disable iff (!reset_n)
      exec_sub |=> flags[amh_pkg::FLAG_C] == ($past(s_r.src_v) > $past(s_r.dst_v)))
      else $error("subtract borrow wrong");
   chk_sub_overflow: assert property (@(posedge clk) disable iff (!reset_n)
      exec_sub |=> flags[amh_pkg::FLAG_Z] == ($past(s_r.dst_v) == $past(s_r.src_v))
      && flags[amh_pkg::FLAG_V] == ($past(s_r.dst_v[7]) != $past(s_r.src_v[7])
      && flags[amh_pkg::FLAG_S] == $past(s_r.src_v[7])))
      else $error("subtract zero or overflow flag wrong");
   chk_mask_no_store: assert property (@(posedge clk) disable iff (!reset_n)
      exec_mask |-> !alu_store)
      else $error("mask test stored a result");
   chk_xor_result: assert property (@(posedge clk) disable iff (!reset_n)
      exec_xor |-> rf_we && rf_addr == s_r.dst_a && (rf_data ^ s_r.src_v) == s_r.dst_v)
      else $error("exclusive or result wrong");
   chk_test_carry: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.st == amh_pkg::AMH_ST_EXEC && (s_r.op == amh_pkg::AMH_OP_ZTM || s_r.op == amh_pkg::AMH_OP_ITM
      || s_r.op == amh_pkg::AMH_OP_XOR) |=> $stable(flags[amh_pkg::FLAG_C]) && !flags[amh_pkg::FLAG_V])
      else $error("logic op touched carry or overflow");
endmodule
`default_nettype wire

// >>> verilog/amh_pkg.sv
// package: shared types and constants for the alu, mask test and halt block
package amh_pkg;
   // =====================================================
   // opcodes
   // =====================================================
   localparam logic [7:0] OP_ASR_R = 8'hd0;
   localparam logic [7:0] OP_ASR_IR = 8'hd1;
   localparam logic [7:0] OP_HALT = 8'h7f;
   localparam logic [7:0] OP_SUB_BASE = 8'h22;
   localparam logic [7:0] OP_ITM_BASE = 8'h62;
   localparam logic [7:0] OP_ZTM_BASE = 8'h72;
   localparam logic [7:0] OP_XOR_BASE = 8'hb2;
   localparam logic [2:0] MODE_RR = 3'h0;
   localparam logic [2:0] MODE_RIR = 3'h1;
   localparam logic [2:0] MODE_GG = 3'h2;
   localparam logic [2:0] MODE_GIR = 3'h3;
   localparam logic [2:0] MODE_GIM = 3'h4;
   // =====================================================
   // halt guard and reset vector
   // =====================================================
   localparam logic [7:0] HALT_KEY = 8'ha5;
   localparam logic [15:0] RESET_VECTOR = 16'h0100;
   localparam logic [7:0] GUARD_RESET = 8'h00;
   localparam logic [3:0] WREG_BASE = 4'hc;
   // =====================================================
   // flag positions
   // =====================================================
   localparam int FLAG_C = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_S = 1;
   localparam int FLAG_V = 0;
   localparam logic [3:0] FLAGS_RESET = 4'h0;

   typedef enum logic [2:0] {AMH_OP_NONE, AMH_OP_ASR, AMH_OP_SUB, AMH_OP_ITM, AMH_OP_ZTM, AMH_OP_XOR,
                             AMH_OP_HALT} amh_op_t;
   typedef enum logic [1:0] {AMH_ST_IDLE, AMH_ST_FETCH, AMH_ST_EXEC, AMH_ST_FROZEN} amh_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] opcode;
      logic [7:0] dst_addr;
      logic [7:0] src_field;
   } amh_instr_t;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] data;
   } amh_wr_t;
endpackage

// >>> verilog/amh_alu.sv
// combinational arithmetic and logic unit with flag generation
`timescale 1ns/1ps
`default_nettype none
module amh_alu (
   input wire amh_pkg::amh_op_t op,
   input wire logic [7:0] dst,
   input wire logic [7:0] src,
   input wire logic [3:0] flags_in,
   output logic [7:0] result,
   output logic store,
   output logic [3:0] flags_out
);
   logic [8:0] diff;
   always_comb begin
      diff = {1'b0, dst} + {1'b0, ~src} + 9'h001;
      result = dst;
      store = 1'b0;
      flags_out = flags_in;
      case (op)
         amh_pkg::AMH_OP_ASR: begin
            result = {dst[7], dst[7:1]};
            store = 1'b1;
            flags_out[amh_pkg::FLAG_C] = dst[0];
            flags_out[amh_pkg::FLAG_V] = 1'b0;
         end
         amh_pkg::AMH_OP_SUB: begin
            result = diff[7:0];
            store = 1'b1;
            flags_out[amh_pkg::FLAG_C] = ~diff[8];
            flags_out[amh_pkg::FLAG_V] = (dst[7] ^ src[7]) & (diff[7] == src[7]);
         end
         amh_pkg::AMH_OP_ITM: begin
            result = ~dst & src;
            flags_out[amh_pkg::FLAG_V] = 1'b0;
         end
         amh_pkg::AMH_OP_ZTM: begin
            result = dst & src;
            flags_out[amh_pkg::FLAG_V] = 1'b0;
         end
         amh_pkg::AMH_OP_XOR: begin
            result = dst ^ src;
            store = 1'b1;
            flags_out[amh_pkg::FLAG_V] = 1'b0;
         end
         default: begin
            result = dst;
         end
      endcase
      if (op != amh_pkg::AMH_OP_NONE && op != amh_pkg::AMH_OP_HALT) begin
         flags_out[amh_pkg::FLAG_Z] = (result == 8'h00);
         flags_out[amh_pkg::FLAG_S] = result[7];
      end
   end
endmodule
`default_nettype wire

// >>> testbench/alu_mask_logic_and_halt_bench.sv
// self-checking bench for the alu, mask test and halt block
`timescale 1ns/1ps
`default_nettype none
module alu_mask_logic_and_halt_bench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ext_irq = 1'b0;
   logic [7:0] rd_addr = 8'h00;
   amh_pkg::amh_instr_t instr = '0;
   amh_pkg::amh_wr_t host_wr = '0;
   logic instr_ready, clk_run, frozen;
   logic [15:0] pc;
   logic [3:0] flags;
   logic [7:0] rd_data, halt_guard_register;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] v;
   logic [15:0] pc_hold;

   amh_core i_amh_core (.clk(clk), .reset_n(reset_n), .instr(instr), .instr_ready(instr_ready),
      .ext_irq(ext_irq), .host_wr(host_wr), .clk_run(clk_run), .frozen(frozen), .pc(pc), .flags(flags),
      .rd_data(rd_data), .rd_addr(rd_addr), .halt_guard_register(halt_guard_register));

   // =====================================================
   // clock, timeout and closing
   // =====================================================
   always #50 clk = ~clk;

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // =====================================================
   // port tasks
   // =====================================================
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk) host_wr = '{1'b1, a, d};
      @(negedge clk) host_wr = '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk) rd_addr = a;
      @(negedge clk) d = rd_data;
   endtask

   // issue one instruction; waits for ready unless fixed is set
   task automatic issue(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s, input bit fixed);
      int n;
      @(negedge clk) instr = '{1'b1, op, d, s};
      @(negedge clk) instr = '0;
      n = 0;
      if (fixed) begin
         repeat (2) @(negedge clk);
      end else begin
         while (instr_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
         end
         check("ready", {15'h0, instr_ready}, 16'h1);
      end
   endtask

   task automatic do_op(input logic [7:0] op, input logic [7:0] d, input logic [7:0] s,
                        input logic [7:0] exp_d, input logic [3:0] exp_f);
      issue(op, d, s, 1'b0);
      rd(d, v);
      check("dest", {8'h0, v}, {8'h0, exp_d});
      check("flags", {12'h0, flags}, {12'h0, exp_f});
   endtask

   // =====================================================
   // scenarios
   // =====================================================
   task automatic t_sub();
      wr(8'h10, 8'h12);
      wr(8'h11, 8'h03);
      do_op(amh_pkg::OP_SUB_BASE + 8'h2, 8'h10, 8'h11, 8'h0f, 4'b0000);
      rd(8'h11, v);
      check("sub source", {8'h0, v}, 16'h0003);
      wr(8'h12, 8'h05);
      do_op(amh_pkg::OP_SUB_BASE + 8'h4, 8'h12, 8'h05, 8'h00, 4'b0100);
      wr(8'h13, 8'h03);
      wr(8'h14, 8'h12);
      do_op(amh_pkg::OP_SUB_BASE + 8'h2, 8'h13, 8'h14, 8'hf1, 4'b1010);
      wr(8'h15, 8'h80);
      do_op(amh_pkg::OP_SUB_BASE + 8'h4, 8'h15, 8'h01, 8'h7f, 4'b0001);
      // working register and register indirect forms
      wr(8'hc1, 8'h12);
      wr(8'hc2, 8'h03);
      do_op(amh_pkg::OP_SUB_BASE, 8'hc1, 8'hc2, 8'h0f, 4'b0000);
      wr(8'hc2, 8'h20);
      wr(8'h20, 8'h05);
      do_op(amh_pkg::OP_SUB_BASE + 8'h1, 8'hc1, 8'hc2, 8'h0a, 4'b0000);
      do_op(amh_pkg::OP_SUB_BASE + 8'h3, 8'h10, 8'hc2, 8'h0a, 4'b0000);
      $display("test sub done");
   endtask

   task automatic t_asr();
      wr(8'h16, 8'h9a);
      do_op(amh_pkg::OP_ASR_R, 8'h16, 8'h00, 8'hcd, 4'b0010);
      wr(8'h17, 8'h18);
      wr(8'h18, 8'hbc);
      do_op(amh_pkg::OP_ASR_IR, 8'h17, 8'h00, 8'h18, 4'b0010);
      rd(8'h18, v);
      check("shift indirect", {8'h0, v}, 16'h00de);
      wr(8'h19, 8'h01);
      do_op(amh_pkg::OP_ASR_R, 8'h19, 8'h00, 8'h00, 4'b1100);
      $display("test shift done");
   endtask

   task automatic t_mask_xor();
      wr(8'h1a, 8'h2b);
      do_op(amh_pkg::OP_ZTM_BASE + 8'h4, 8'h1a, 8'h54, 8'h2b, 4'b1100);
      do_op(amh_pkg::OP_ZTM_BASE + 8'h4, 8'h1a, 8'h8a, 8'h2b, 4'b1000);
      wr(8'h1b, 8'h00);
      do_op(amh_pkg::OP_ITM_BASE + 8'h4, 8'h1b, 8'h80, 8'h00, 4'b1010);
      wr(8'h1c, 8'hc7);
      wr(8'h1d, 8'h02);
      do_op(amh_pkg::OP_ITM_BASE + 8'h2, 8'h1c, 8'h1d, 8'hc7, 4'b1100);
      do_op(amh_pkg::OP_XOR_BASE + 8'h2, 8'h1c, 8'h1d, 8'hc5, 4'b1010);
      do_op(amh_pkg::OP_XOR_BASE + 8'h4, 8'h1c, 8'hc5, 8'h00, 4'b1100);
      $display("test mask and xor done");
   endtask

   task automatic t_halt_noguard();
      issue(amh_pkg::OP_HALT, 8'h00, 8'h00, 1'b1);
      check("frozen", {15'h0, frozen}, 16'h0);
      check("pc", pc, amh_pkg::RESET_VECTOR);
      check("flags", {12'h0, flags}, 16'h000c);
      $display("test halt without key done");
   endtask

   task automatic t_halt_irq();
      wr(8'hff, amh_pkg::HALT_KEY);
      check("guard", {8'h0, halt_guard_register}, {8'h0, amh_pkg::HALT_KEY});
      issue(amh_pkg::OP_HALT, 8'h00, 8'h00, 1'b1);
      check("frozen", {15'h0, frozen}, 16'h1);
      check("clk_run", {15'h0, clk_run}, 16'h0);
      pc_hold = pc;
      @(negedge clk) host_wr = '{1'b1, 8'h1c, 8'h55};
      instr = '{1'b1, amh_pkg::OP_XOR_BASE + 8'h4, 8'h1c, 8'hff};
      repeat (6) @(negedge clk);
      host_wr = '0;
      instr = '0;
      repeat (4) @(negedge clk);
      check("frozen hold", {15'h0, frozen}, 16'h1);
      check("pc hold", pc, pc_hold);
      check("flags hold", {12'h0, flags}, 16'h000c);
      ext_irq = 1'b1;
      for (int n = 0; n < 10 && frozen !== 1'b0; n++) @(negedge clk);
      check("irq wake", {15'h0, frozen}, 16'h0);
      ext_irq = 1'b0;
      rd(8'h1c, v);
      check("reg hold", {8'h0, v}, 16'h0000);
      $display("test halt and interrupt wake done");
   endtask

   task automatic t_halt_reset();
      wr(8'hff, amh_pkg::HALT_KEY);
      issue(amh_pkg::OP_HALT, 8'h00, 8'h00, 1'b1);
      check("frozen", {15'h0, frozen}, 16'h1);
      // reset held low across the settling interval before release
      @(negedge clk) reset_n = 1'b0;
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      check("reset wake", {15'h0, frozen}, 16'h0);
      check("pc", pc, amh_pkg::RESET_VECTOR);
      check("guard", {8'h0, halt_guard_register}, {8'h0, amh_pkg::GUARD_RESET});
      rd(8'h16, v);
      check("reg kept", {8'h0, v}, 16'h00cd);
      $display("test halt and reset wake done");
   endtask

   initial begin
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      t_sub();
      t_asr();
      t_mask_xor();
      t_halt_noguard();
      t_halt_irq();
      t_halt_reset();
      conclude();
   end
endmodule
`default_nettype wire
